// ===== hdl/ccpp_pkg.sv
/*
 * Shared constants for the converter clock and post-processing block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 200 MHz system clock and 32-bit AXI4-Lite register access.
 */
package ccpp_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned SLOW_OSC_HZ = 10_000;
	localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
	localparam int unsigned OUT_CLK_HZ = 32_768;
	localparam int unsigned OUT_CLK_HALF = CLK_HZ / (2 * OUT_CLK_HZ);
	localparam int unsigned START_STEP_US = 100;
	localparam int unsigned START_STEP_CYCLES = START_STEP_US * (CLK_HZ / 1_000_000);

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CFG0 = 8'h00;
	localparam logic [7:0] OFS_CFG3 = 8'h0c;
	localparam logic [7:0] OFS_GAIN1 = 8'h10;
	localparam logic [7:0] OFS_GAIN4 = 8'h1c;
	localparam logic [7:0] OFS_CFG12 = 8'h30;
	localparam logic [7:0] OFS_CFG13 = 8'h34;
	localparam logic [7:0] OFS_PPCTRL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;
	localparam logic [7:0] OFS_RESULT0 = 8'h50;
	localparam logic [7:0] OFS_RESULT3 = 8'h5c;

	// ==========================================================
	// Field positions
	localparam int unsigned BIT_RC_SUPPLY_INT = 0;
	localparam int unsigned POS_OSC_START = 17;
	localparam int unsigned BIT_EMI_ENABLE = 7;
	localparam int unsigned BIT_FAST_RC = 0;
	localparam int unsigned BIT_LOWPOWER_RC = 1;
	localparam int unsigned BIT_CORR_EN = 0;
	localparam int unsigned POS_CORR_FACTOR = 8;
	localparam int unsigned BIT_USER_PRG = 16;

	// ==========================================================
	// Values
	localparam logic [23:0] CFG_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h100000;
	localparam int unsigned GAIN_FRAC = 20;
	localparam int unsigned CORR_SHIFT = 21;
	localparam logic [7:0] CORR_FACTOR_RESET = 8'hf7;
	localparam logic [2:0] OSC_OFF = 3'h0;
	localparam logic [2:0] OSC_ALWAYS = 3'h1;
	localparam logic [2:0] OSC_DELAY_MIN = 3'h2;
	localparam logic [2:0] OSC_DELAY_MAX = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CCPP_IDLE,
		CCPP_SCALE,
		CCPP_DIVIDE,
		CCPP_STORE,
		CCPP_FINISH
	} ccpp_pp_state_t;
endpackage : ccpp_pkg

// ===== hdl/ccpp_divider.sv
/*
 * Unsigned restoring divider, one quotient bit per clock.
 * Assumes the caller never starts it with a zero divisor.
 */
`timescale 1ns/10ps
module ccpp_divider #(
	parameter int unsigned NUM_W = 49,
	parameter int unsigned DEN_W = 33
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [NUM_W-1:0] numerator,
	input wire logic [DEN_W-1:0] denominator,
	output logic busy,
	output logic done,
	output logic [NUM_W-1:0] quotient
);
	logic [DEN_W:0] remainder;
	logic [DEN_W-1:0] divisor;
	logic [$clog2(NUM_W+1)-1:0] bits_left;
	logic [DEN_W:0] trial;

	always_comb begin
		trial = {remainder[DEN_W-1:0], quotient[NUM_W-1]} - {1'b0, divisor};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			remainder <= '0;
			divisor <= '0;
			quotient <= '0;
			bits_left <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				remainder <= '0;
				divisor <= denominator;
				quotient <= numerator;
				bits_left <= ($clog2(NUM_W+1))'(NUM_W);
				busy <= 1'b1;
			end else if (busy) begin
				if (trial[DEN_W]) begin
					remainder <= {remainder[DEN_W-1:0], quotient[NUM_W-1]};
					quotient <= {quotient[NUM_W-2:0], 1'b0};
				end else begin
					remainder <= trial;
					quotient <= {quotient[NUM_W-2:0], 1'b1};
				end
				bits_left <= bits_left - 1'b1;
				if (bits_left == 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : ccpp_divider

// ===== hdl/ccpp_top.sv
/*
 * Measurement clock selection, result post-processing and port ground
 * clamping for a strain-gauge time-to-digital converter, with AXI4-Lite
 * registers. Assumes the front-end signals are synchronous to clk.
 */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps

module ccpp_top
	import ccpp_pkg::*;
#(
	parameter int unsigned START_STEP = ccpp_pkg::START_STEP_CYCLES,
	parameter int unsigned SLOW_PERIOD = ccpp_pkg::SLOW_DIV,
	parameter int unsigned SUPPLY_W = 24
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic meas_request,
	input wire logic meas_done,
	input wire logic [1:0] measured_port,
	input wire logic native_mode,
	input wire logic stretched_mode,
	input wire logic measuring_range1,
	input wire logic [95:0] halfbridge_result,
	input wire logic [SUPPLY_W-1:0] measured_supply_voltage,
	output logic meas_start,
	output logic resonator_enable,
	output logic fast_rc_osc_enable,
	output logic lowpower_rc_osc_enable,
	output logic rc_osc_supply_internal,
	output logic slow_tick,
	output logic cycle_timing_slow,
	output logic clk32k_out,
	output logic [3:0] port_ground_clamp,
	output logic user_program_start,
	output logic postproc_done
);
	import ccpp_pkg::*;

	// ==========================================================
	// Register bus
	logic [23:0] cfg0, cfg3, cfg12, cfg13, ppctrl;
	logic [23:0] gain [4];
	logic [23:0] result [4];
	logic [7:0] aw_addr, ar_addr;
	logic aw_held, w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic pp_busy;

	function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [23:0] v;
		v = old;
		for (int i = 0; i < 3; i++) begin
			if (strb[i])
				v[i*8 +: 8] = data[i*8 +: 8];
		end
		return v;
	endfunction : merge

	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_CFG0 || a == OFS_CFG3 || a == OFS_CFG12 || a == OFS_CFG13
			|| a == OFS_PPCTRL || a == OFS_STATUS
			|| (a >= OFS_GAIN1 && a <= OFS_GAIN4 && a[1:0] == 2'b00)
			|| (a >= OFS_RESULT0 && a <= OFS_RESULT3 && a[1:0] == 2'b00);
	endfunction : is_mapped

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg0 <= CFG_RESET;
			cfg3 <= CFG_RESET;
			cfg12 <= CFG_RESET;
			cfg13 <= CFG_RESET;
			ppctrl <= 24'(CORR_FACTOR_RESET) << POS_CORR_FACTOR;
			for (int i = 0; i < 4; i++)
				gain[i] <= GAIN_RESET;
		end else if (do_write) begin
			case (aw_addr)
				OFS_CFG0: cfg0 <= merge(cfg0, w_data, w_strb);
				OFS_CFG3: cfg3 <= merge(cfg3, w_data, w_strb);
				OFS_CFG12: cfg12 <= merge(cfg12, w_data, w_strb);
				OFS_CFG13: cfg13 <= merge(cfg13, w_data, w_strb);
				OFS_PPCTRL: ppctrl <= merge(ppctrl, w_data, w_strb);
				default: begin
					if (aw_addr >= OFS_GAIN1 && aw_addr <= OFS_GAIN4 && aw_addr[1:0] == 2'b00)
						gain[aw_addr[3:2]] <= merge(gain[aw_addr[3:2]], w_data, w_strb);
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFS_CFG0: s_axi_rdata <= {8'h00, cfg0};
				OFS_CFG3: s_axi_rdata <= {8'h00, cfg3};
				OFS_CFG12: s_axi_rdata <= {8'h00, cfg12};
				OFS_CFG13: s_axi_rdata <= {8'h00, cfg13};
				OFS_PPCTRL: s_axi_rdata <= {8'h00, ppctrl};
				OFS_STATUS: s_axi_rdata <= {27'h0, pp_busy, lowpower_rc_osc_enable,
					fast_rc_osc_enable, resonator_enable, cycle_timing_slow};
				default: begin
					if (is_mapped(s_axi_araddr) && s_axi_araddr >= OFS_RESULT0)
						s_axi_rdata <= {{8{result[s_axi_araddr[3:2]][23]}},
							result[s_axi_araddr[3:2]]};
					else if (is_mapped(s_axi_araddr))
						s_axi_rdata <= {8'h00, gain[s_axi_araddr[3:2]]};
					else
						s_axi_rdata <= '0;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Oscillators and measurement start
	logic [2:0] osc_start;
	logic fast_rc_sel, lowpower_rc_sel;
	logic [19:0] slow_count;
	logic [19:0] start_count;
	logic [19:0] start_target;
	logic starting, meas_active;
	logic [$clog2(OUT_CLK_HALF+1)-1:0] out_count;

	assign osc_start = cfg3[POS_OSC_START +: 3];
	assign fast_rc_sel = cfg13[BIT_FAST_RC];
	assign lowpower_rc_sel = cfg13[BIT_LOWPOWER_RC] && !fast_rc_sel;
	assign fast_rc_osc_enable = fast_rc_sel;
	assign lowpower_rc_osc_enable = lowpower_rc_sel;
	assign rc_osc_supply_internal = cfg0[BIT_RC_SUPPLY_INT];
	assign cycle_timing_slow = stretched_mode || measuring_range1;
	assign start_target = 20'((osc_start - OSC_ALWAYS) * START_STEP);

	// The slow oscillator never stops, so its tick runs whatever the other settings.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			slow_count <= '0;
			slow_tick <= 1'b0;
		end else begin
			slow_tick <= 1'b0;
			if (slow_count == 20'(SLOW_PERIOD - 1)) begin
				slow_count <= '0;
				slow_tick <= 1'b1;
			end else begin
				slow_count <= slow_count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_count <= '0;
			clk32k_out <= 1'b0;
		end else if (out_count == ($bits(out_count))'(OUT_CLK_HALF - 1)) begin
			out_count <= '0;
			clk32k_out <= !clk32k_out;
		end else begin
			out_count <= out_count + 1'b1;
		end
	end

	// Under an RC source the resonator stays off and a request starts at once.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resonator_enable <= 1'b0;
			starting <= 1'b0;
			start_count <= '0;
			meas_start <= 1'b0;
			meas_active <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			if (meas_done)
				meas_active <= 1'b0;
			if (fast_rc_sel || lowpower_rc_sel || osc_start == OSC_OFF || osc_start > OSC_DELAY_MAX) begin
				resonator_enable <= 1'b0;
				starting <= 1'b0;
				if (meas_request && !meas_active) begin
					meas_start <= 1'b1;
					meas_active <= 1'b1;
				end
			end else if (osc_start == OSC_ALWAYS) begin
				resonator_enable <= 1'b1;
				starting <= 1'b0;
				if (meas_request && !meas_active) begin
					meas_start <= 1'b1;
					meas_active <= 1'b1;
				end
			end else if (starting) begin
				if (start_count == start_target - 1'b1) begin
					starting <= 1'b0;
					meas_start <= 1'b1;
					meas_active <= 1'b1;
				end else begin
					start_count <= start_count + 1'b1;
				end
			end else if (meas_request && !meas_active) begin
				resonator_enable <= 1'b1;
				starting <= 1'b1;
				start_count <= '0;
			end else if (meas_done) begin
				resonator_enable <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Port ground clamping
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			port_ground_clamp <= 4'h0;
		else if (meas_active && native_mode && cfg12[BIT_EMI_ENABLE])
			port_ground_clamp <= ~(4'h1 << measured_port);
		else
			port_ground_clamp <= 4'h0;
	end

	// ==========================================================
	// Post-processing
	ccpp_pp_state_t state;
	logic [1:0] index;
	logic [23:0] raw [4];
	logic [27:0] scaled_mag;
	logic negative;
	logic corr_en;
	logic signed [7:0] corr_factor;
	logic signed [33:0] corr_den;
	logic div_start, div_busy, div_done;
	logic [48:0] div_quot;
	logic [48:0] final_mag;
	logic [23:0] abs_raw;
	logic [47:0] product;

	assign corr_en = ppctrl[BIT_CORR_EN];
	assign corr_factor = signed'(ppctrl[POS_CORR_FACTOR +: 8]);
	assign abs_raw = raw[index][23] ? 24'(-raw[index]) : raw[index];
	assign product = abs_raw * gain[index];
	assign corr_den = (34'sd1 <<< CORR_SHIFT)
		+ signed'(34'(measured_supply_voltage)) * corr_factor;
	assign pp_busy = state != CCPP_IDLE;

	ccpp_divider #(
		.NUM_W(49),
		.DEN_W(33)
	) u_divider (
		.clk(clk),
		.reset_n(reset_n),
		.start(div_start),
		.numerator(49'(scaled_mag) << CORR_SHIFT),
		.denominator(corr_den > 0 ? 33'(corr_den) : 33'h000000001),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_quot)
	);

	// Magnitudes above the signed 24-bit range saturate rather than wrap.
	always_comb begin
		final_mag = corr_en ? div_quot : 49'(scaled_mag);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= CCPP_IDLE;
			index <= '0;
			scaled_mag <= '0;
			negative <= 1'b0;
			div_start <= 1'b0;
			user_program_start <= 1'b0;
			postproc_done <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				raw[i] <= '0;
				result[i] <= '0;
			end
		end else begin
			div_start <= 1'b0;
			user_program_start <= 1'b0;
			postproc_done <= 1'b0;
			case (state)
				CCPP_IDLE: begin
					if (meas_done) begin
						for (int i = 0; i < 4; i++)
							raw[i] <= halfbridge_result[i*24 +: 24];
						index <= '0;
						state <= CCPP_SCALE;
					end
				end
				CCPP_SCALE: begin
					scaled_mag <= product[GAIN_FRAC +: 28];
					negative <= raw[index][23];
					if (corr_en) begin
						div_start <= 1'b1;
						state <= CCPP_DIVIDE;
					end else begin
						state <= CCPP_STORE;
					end
				end
				CCPP_DIVIDE: begin
					if (div_done)
						state <= CCPP_STORE;
				end
				CCPP_STORE: begin
					if (|final_mag[48:23])
						result[index] <= negative ? 24'h800001 : 24'h7fffff;
					else
						result[index] <= negative ? -{1'b0, final_mag[22:0]} : {1'b0, final_mag[22:0]};
					index <= index + 1'b1;
					state <= index == 2'd3 ? CCPP_FINISH : CCPP_SCALE;
				end
				CCPP_FINISH: begin
					postproc_done <= 1'b1;
					user_program_start <= ppctrl[BIT_USER_PRG];
					state <= CCPP_IDLE;
				end
				default: state <= CCPP_IDLE;
			endcase
		end
	end
endmodule : ccpp_top

// ===== verification/ccpp_checker.sv
/*
 * Port-level assertions for the clock and post-processing block.
 * Assumes it is bound into ccpp_top and sees only that module's ports.
 */
`timescale 1ns/10ps
module ccpp_checker #(
	parameter int unsigned SLOW_PERIOD = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic meas_start,
	input wire logic meas_done,
	input wire logic [1:0] measured_port,
	input wire logic native_mode,
	input wire logic stretched_mode,
	input wire logic measuring_range1,
	input wire logic fast_rc_osc_enable,
	input wire logic lowpower_rc_osc_enable,
	input wire logic slow_tick,
	input wire logic cycle_timing_slow,
	input wire logic [3:0] port_ground_clamp,
	input wire logic user_program_start,
	input wire logic postproc_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Measurement window seen from the ports.
	logic busy_q;
	logic busy_now;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
		end else if (meas_start) begin
			busy_q <= 1'b1;
		end else if (meas_done) begin
			busy_q <= 1'b0;
		end
	end
	assign busy_now = busy_q | meas_start;
	// Cycles since the last slow tick; a counter keeps long periods cheap to check.
	logic [31:0] tick_gap;
	logic tick_seen;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_gap <= '0;
			tick_seen <= 1'b0;
		end else if (slow_tick) begin
			tick_gap <= '0;
			tick_seen <= 1'b1;
		end else begin
			tick_gap <= tick_gap + 32'h1;
		end
	end
	// ==========================================================
	// Assertions
	chk_clamp_release: assert property (
		port_ground_clamp != 4'h0 |-> port_ground_clamp == ~(4'h1 << $past(measured_port)))
		else $error("clamp pattern does not release only the measured port");
	chk_clamp_native: assert property (
		port_ground_clamp != 4'h0 |-> $past(native_mode))
		else $error("clamp active outside native mode");
	chk_clamp_window: assert property (
		port_ground_clamp != 4'h0 |-> busy_now || $past(busy_now))
		else $error("clamp active outside a measurement");
	chk_timing_source: assert property (
		cycle_timing_slow == (stretched_mode || measuring_range1))
		else $error("cycle timing source wrong");
	chk_rc_single: assert property (
		!(fast_rc_osc_enable && lowpower_rc_osc_enable))
		else $error("two rc clocks enabled");
	chk_tick_period: assert property (
		tick_gap <= 32'(SLOW_PERIOD)
		&& (!(slow_tick && tick_seen) || tick_gap == 32'(SLOW_PERIOD - 1)))
		else $error("slow tick period wrong");
	chk_done_bound: assert property (
		meas_done |-> ##[1:600] postproc_done)
		else $error("post-processing did not finish");
	chk_done_pulse: assert property (
		postproc_done |=> !postproc_done)
		else $error("done longer than one cycle");
	chk_user_pulse: assert property (
		user_program_start |=> !user_program_start)
		else $error("user start longer than one cycle");
endmodule : ccpp_checker

bind ccpp_top ccpp_checker #(.SLOW_PERIOD(SLOW_PERIOD)) chk_u (
	.clk(clk), .reset_n(reset_n), .meas_start(meas_start), .meas_done(meas_done),
	.measured_port(measured_port), .native_mode(native_mode),
	.stretched_mode(stretched_mode), .measuring_range1(measuring_range1),
	.fast_rc_osc_enable(fast_rc_osc_enable), .lowpower_rc_osc_enable(lowpower_rc_osc_enable),
	.slow_tick(slow_tick), .cycle_timing_slow(cycle_timing_slow),
	.port_ground_clamp(port_ground_clamp), .user_program_start(user_program_start),
	.postproc_done(postproc_done)
);

// ===== verification/ccpp_frontend_model.sv
/*
 * Front-end model: answers each measurement start with a done pulse.
 * Assumes one measurement at a time; slow selects a long conversion.
 */
`timescale 1ns/10ps
module ccpp_frontend_model #(
	parameter logic [95:0] RESULTS = 96'h0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic meas_start,
	input wire logic slow,
	output logic meas_done,
	output logic [95:0] halfbridge_result
);
	int cnt;
	logic run;
	logic [23:0] junk;
	// Results are valid only with done; otherwise the lines churn.
	assign halfbridge_result = meas_done ? RESULTS : {4{junk}};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run <= 1'b0;
			cnt <= 0;
			meas_done <= 1'b0;
			junk <= 24'h5a5a5a;
		end else begin
			junk <= junk + 24'h0f1e2d;
			meas_done <= 1'b0;
			if (meas_start) begin
				run <= 1'b1;
				cnt <= slow ? 40 : 4;
			end else if (run && cnt == 0) begin
				run <= 1'b0;
				meas_done <= 1'b1;
			end else if (run) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : ccpp_frontend_model

// ===== verification/ccpp_bench.sv
/*
 * Self-checking bench: AXI4-Lite tasks, measurement runs and port checks.
 * Assumes the front-end model and the bound checker are compiled with it.
 */
`timescale 1ns/10ps
module ccpp_bench;
	import ccpp_pkg::*;
	localparam int unsigned STEP = 20;
	localparam logic [95:0] RAW = {24'h000400, 24'h123456, 24'hfff800, 24'h001000};
	logic clk = 1'b0, reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, at, wt;
	logic [1:0] bresp, rresp, rsp, measured_port = 2'h0;
	logic meas_request = 1'b0, native_mode = 1'b0, stretched_mode = 1'b0;
	logic measuring_range1 = 1'b0, slow = 1'b0, meas_done, meas_start, resonator_enable;
	logic fast_rc_osc_enable, lowpower_rc_osc_enable, rc_osc_supply_internal, clk32k_out;
	logic cycle_timing_slow, user_program_start, postproc_done;
	logic [95:0] halfbridge_result;
	logic [23:0] measured_supply_voltage = 24'h0;
	logic [3:0] port_ground_clamp, clamp_seen;
	int miscompares = 0, check_count = 0, cycles = 0, user_starts = 0, lat;
	always #2.5 clk = ~clk;
	ccpp_top #(.START_STEP(STEP), .SLOW_PERIOD(16), .SUPPLY_W(24)) dut_u (
		.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas_request(meas_request), .meas_done(meas_done), .measured_port(measured_port),
		.native_mode(native_mode), .stretched_mode(stretched_mode),
		.measuring_range1(measuring_range1), .halfbridge_result(halfbridge_result),
		.measured_supply_voltage(measured_supply_voltage), .meas_start(meas_start),
		.resonator_enable(resonator_enable), .fast_rc_osc_enable(fast_rc_osc_enable),
		.lowpower_rc_osc_enable(lowpower_rc_osc_enable), .slow_tick(),
		.rc_osc_supply_internal(rc_osc_supply_internal), .clk32k_out(clk32k_out),
		.cycle_timing_slow(cycle_timing_slow), .port_ground_clamp(port_ground_clamp),
		.user_program_start(user_program_start), .postproc_done(postproc_done));
	ccpp_frontend_model #(.RESULTS(RAW)) model_u (.clk(clk), .reset_n(reset_n),
		.meas_start(meas_start), .slow(slow), .meas_done(meas_done),
		.halfbridge_result(halfbridge_result));
	// ==========================================================
	// Tasks
	task wrap_up();
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp_word
	task cmp_bit(input string name, input logic exp, input logic got);
		cmp_word(name, {31'h0, exp}, {31'h0, got});
	endtask : cmp_bit
	task cmp_int(input string name, input int exp, input int got);
		cmp_word(name, exp, got);
	endtask : cmp_int
	// Ready and answers are looked at on the falling edge, so the rising
	// edge that follows is the one that moves the item.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge clk);
			at = awvalid & awready;
			wt = wvalid & wready;
			rsp = bresp;
			if (bvalid === 1'b1)
				break;
			@(posedge clk);
			if (at)
				awvalid <= 1'b0;
			if (wt)
				wvalid <= 1'b0;
		end
		@(posedge clk);
		bready <= 1'b0;
	endtask : wr
	task rdw(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge clk);
			at = arvalid & arready;
			rd = rdata;
			rsp = rresp;
			if (rvalid === 1'b1)
				break;
			@(posedge clk);
			if (at)
				arvalid <= 1'b0;
		end
		@(posedge clk);
		rready <= 1'b0;
	endtask : rdw
	task measure();
		@(posedge clk);
		meas_request <= 1'b1;
		lat = 0;
		forever begin
			@(negedge clk);
			lat++;
			if (meas_start === 1'b1)
				break;
		end
		@(posedge clk);
		meas_request <= 1'b0;
		repeat (2) @(negedge clk);
		clamp_seen = port_ground_clamp;
		do @(negedge clk); while (postproc_done !== 1'b1);
	endtask : measure
	always @(negedge clk) begin
		cycles++;
		if (user_program_start === 1'b1)
			user_starts++;
		if (cycles == 40000) begin
			miscompares++;
			wrap_up();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		static logic [31:0] scaled [4] = '{32'h800, 32'hfffff000, 32'h123456, 32'h600};
		static logic [23:0] pp [4] = '{24'h00f700, 24'h008001, 24'h004001, 24'h01f700};
		static logic [23:0] sup [4] = '{24'h002000, 24'h002000, 24'h008000, 24'h002000};
		logic signed [31:0] ev;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rdw(OFS_PPCTRL);
		cmp_word("ppctrl reset", 32'h0000f700, rd);
		rdw(OFS_GAIN4);
		cmp_word("gain reset", {8'h00, GAIN_RESET}, rd);
		rdw(8'h80);
		cmp_word("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		wr(8'h80, 32'h1);
		cmp_word("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CFG13, i);
			wr(OFS_CFG0, i);
			cmp_bit("fast rc", i[0], fast_rc_osc_enable);
			cmp_bit("lowpower rc", i == 2, lowpower_rc_osc_enable);
			cmp_bit("rc supply", i[0], rc_osc_supply_internal);
			@(posedge clk);
			stretched_mode <= i[0];
			measuring_range1 <= i[1];
			@(negedge clk);
			cmp_bit("slow timing", i != 0, cycle_timing_slow);
		end
		wr(OFS_CFG13, 0);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CFG3, i << 17);
			measure();
			cmp_int("start delay", (i >= 2 && i <= 5) ? (i - 1) * STEP + 2 : 2, lat);
			cmp_bit("resonator after", i == 1, resonator_enable);
		end
		wr(OFS_CFG13, 1);
		wr(OFS_CFG3, 5 << 17);
		measure();
		cmp_int("rc start delay", 2, lat);
		cmp_bit("resonator with rc", 1'b0, resonator_enable);
		wr(8'h10, 32'h080000);
		wr(8'h14, 32'h200000);
		wr(8'h18, 32'h100000);
		wr(OFS_GAIN4, 32'h180000);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_PPCTRL, pp[c]);
			@(posedge clk);
			measured_supply_voltage <= sup[c];
			slow <= c[0];
			user_starts = 0;
			measure();
			for (int i = 0; i < 4; i++) begin
				rdw(8'h50 + 8'(4 * i));
				ev = scaled[i];
				if (c == 1)
					ev = ev <<< 1;
				if (c == 2)
					ev = ev >>> 1;
				cmp_word("result", ev, rd);
			end
			cmp_int("user starts", c == 3, user_starts);
		end
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CFG12, k == 1 ? 32'h0 : 32'h80);
			@(posedge clk);
			native_mode <= k != 2;
			measured_port <= 2'(k + 1);
			measure();
			cmp_word("clamp", k == 0 ? {28'h0, ~(4'h1 << (k + 1))} : 32'h0, {28'h0, clamp_seen});
		end
		@(posedge clk32k_out);
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (clk32k_out === 1'b1);
		cmp_int("clk32k half period", OUT_CLK_HALF + 1, lat);
		wrap_up();
	end
endmodule : ccpp_bench
